// ===== inc/esh_pkg.sv
/*
  shared constants for the encoder serial host port: register indices,
  reset images, bit positions and the protocol state type.
  assumes nothing beyond a SystemVerilog compiler.
*/
package esh_pkg;

  // ==========================================================
  // register space
  localparam int unsigned ESH_REGS_COPY = 36;
  localparam int unsigned ESH_REGS_OSD  = 31;
  localparam int unsigned ESH_PTR_W     = 6;
  localparam int unsigned ESH_FREQ_N    = 4;

  localparam logic [5:0] ESH_IDX_MODE0 = 6'h00;
  localparam logic [5:0] ESH_IDX_FREQ0 = 6'h02;
  localparam logic [5:0] ESH_IDX_CTRL  = 6'h3e;
  localparam logic [5:0] ESH_IDX_STAT  = 6'h3f;

  // ==========================================================
  // reset images
  localparam logic [7:0]  ESH_MODE0_RST = 8'h04;
  localparam logic [7:0]  ESH_ZERO_RST  = 8'h00;
  localparam logic [31:0] ESH_FREQ_RST  = 32'h21f07c16;
  localparam logic [7:0]  ESH_CTRL_RST  = 8'h01;

  // ==========================================================
  // field positions
  localparam int unsigned ESH_CTRL_EN   = 0;
  localparam int unsigned ESH_STAT_BUSY = 0;
  localparam int unsigned ESH_STAT_READ = 1;
  localparam int unsigned ESH_STAT_DRV  = 2;
  localparam logic [3:0]  ESH_BITS_BYTE = 4'h8;

  // ==========================================================
  // protocol states
  typedef enum logic [3:0] {
    ESH_IDLE,
    ESH_ADDR,
    ESH_SUB,
    ESH_WR,
    ESH_ACK_ADDR,
    ESH_ACK_DATA,
    ESH_RD,
    ESH_MACK,
    ESH_MACK_OK
  } esh_state_t;

endpackage

// ===== core/esh_sync.sv
/*
  two-flop synchroniser for a group of pin levels, plus one delayed copy
  of the synchronised value for edge detection.
  assumes inputs are asynchronous to clock.
*/
`timescale 1ns/100ps
module esh_sync #(
  parameter int unsigned WIDTH = 3
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pins,
  output      logic [WIDTH-1:0] now,
  output      logic [WIDTH-1:0] prev
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
  } esh_sync_st_t;

  esh_sync_st_t q, d;

  // idle bus lines are high, so reset to high to avoid a false start
  always_comb begin
    d    = q;
    d.s1 = pins;
    d.s2 = q.s1;
    d.s3 = q.s2;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q <= '1;
    end else begin
      q <= d;
    end
  end

  assign now  = q.s2;
  assign prev = q.s3;

endmodule // esh_sync

// ===== core/esh_regfile.sv
/*
  configuration register storage in flip-flops, one write port and two
  read ports, with the documented reset image.
  assumes one write per cycle, already arbitrated by the caller.
*/
`timescale 1ns/100ps
module esh_regfile
  import esh_pkg::*;
#(
  parameter int unsigned NUM = ESH_REGS_COPY
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        we,
  input  wire logic [5:0]  waddr,
  input  wire logic [7:0]  wdata,
  input  wire logic [5:0]  raddr_a,
  output      logic [7:0]  rdata_a,
  input  wire logic [5:0]  raddr_b,
  output      logic [7:0]  rdata_b,
  output      logic [7:0]  mode0,
  output      logic [31:0] freq
);

  if (NUM < 6 || NUM > 62) begin : g_bad_num
    $error("esh_regfile: NUM out of range");
  end

  // ==========================================================
  // state and reset image
  typedef struct packed {
    logic [NUM-1:0][7:0] mem;
  } esh_rf_st_t;

  function automatic esh_rf_st_t rst_image();
    esh_rf_st_t r;
    r = '0;
    for (int i = 0; i < NUM; i++) begin
      r.mem[i] = ESH_ZERO_RST;
    end
    r.mem[ESH_IDX_MODE0] = ESH_MODE0_RST;
    for (int k = 0; k < ESH_FREQ_N; k++) begin
      r.mem[int'(ESH_IDX_FREQ0) + k] = ESH_FREQ_RST[8*k +: 8];
    end
    return r;
  endfunction

  localparam esh_rf_st_t RST = rst_image();

  esh_rf_st_t q, d;

  always_comb begin
    d = q;
    for (int i = 0; i < NUM; i++) begin
      if (we && waddr == 6'(i)) begin
        d.mem[i] = wdata;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // reads; out-of-range index reads zero
  assign rdata_a = (int'(raddr_a) < NUM) ? q.mem[raddr_a] : ESH_ZERO_RST;
  assign rdata_b = (int'(raddr_b) < NUM) ? q.mem[raddr_b] : ESH_ZERO_RST;
  assign mode0   = q.mem[ESH_IDX_MODE0];

  for (genvar k = 0; k < ESH_FREQ_N; k++) begin : g_freq
    assign freq[8*k +: 8] = q.mem[int'(ESH_IDX_FREQ0) + k];
  end

endmodule // esh_regfile

// ===== core/esh_port.sv
/*
  two-wire serial slave port of a video encoder: address match, write-only
  subaddress pointer with auto-increment, register reads and writes, plus
  a local register port for on-chip logic.
  assumes the bus pins are asynchronous and sampled here by clock; the data
  pin is open-drain, resolved outside from serial_data_oe.
*/
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps

// Functional notes
// - a falling data line while clock stays high starts a transfer.
// - first byte is seven address bits then direction, msb first, one reads.
// - matching address is acknowledged on ninth pulse, otherwise go idle.
// - one of two addresses; address bit zero, byte bit one, comes from the select pin.
// - second byte of a write is the starting subaddress.
// - pointer advances by one after each written byte and each acked read byte, stopping at the top on reads.
// - thirty-six registers with copy protection, thirty-one otherwise.
// - a stop anywhere returns at once to idle; a start anywhere restarts the address byte.
// - invalid subaddress gets no acknowledge and the port goes idle.
// - reads past the top keep returning the highest register until nack.
// - writes past the top are dropped, not acknowledged, then idle.
// - reset selects the low pixel byte inputs as pixel source.
// - reset selects the north american standard and the frequency code.
// - reset clears all other registers to zero.
// - reset clears the first mode register except the pedestal enable bit.
// - pointer is write-only and chooses the register of each access.
module esh_port
  import esh_pkg::*;
#(
  parameter bit         HAS_COPY_PROT = 1'b1,
  parameter logic [5:0] SLAVE_ID      = 6'h15  // arbitrary value
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        serial_clock_pin,
  input  wire logic        serial_data_in,
  output      logic        serial_data_out,
  output      logic        serial_data_oe,
  input  wire logic        address_select_pin,
  input  wire logic [5:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output      logic [7:0]  reg_rdata,
  output      logic [7:0]  first_mode_register,
  output      logic [31:0] subcarrier_freq,
  output      logic        low_pixel_byte_inputs_sel
);

  // ==========================================================
  // register space size
  localparam int unsigned NUM_REGS = HAS_COPY_PROT ? ESH_REGS_COPY : ESH_REGS_OSD;
  localparam logic [7:0]  NUM_B    = 8'(NUM_REGS);
  localparam logic [5:0]  NUM_P    = 6'(NUM_REGS);
  localparam logic [5:0]  LAST_P   = 6'(NUM_REGS - 1);

  if (NUM_REGS > 62) begin : g_bad_num
    $error("esh_port: register space overlaps local registers");
  end

  // ==========================================================
  // state
  typedef struct packed {
    esh_state_t  st;
    logic [3:0]  bits;
    logic [7:0]  sh;
    logic [5:0]  ptr;
    logic        rd_dir;
    logic        oe;
    logic [7:0]  ctrl;
    logic [7:0]  rdata;
    logic        pix_low;
  } esh_port_st_t;

  esh_port_st_t q, d;

  // reset image: idle, port enabled, low pixel byte selected
  function automatic esh_port_st_t rst_state();
    esh_port_st_t r;
    r         = '0;
    r.st      = ESH_IDLE;
    r.ctrl    = ESH_CTRL_RST;
    r.pix_low = 1'b1;
    return r;
  endfunction

  localparam esh_port_st_t RST = rst_state();

  // ==========================================================
  // pin sampling
  logic [2:0] now;
  logic [2:0] prev;

  esh_sync #(
    .WIDTH (3)
  ) u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .pins  ({address_select_pin, serial_data_in, serial_clock_pin}),
    .now   (now),
    .prev  (prev)
  );

  logic scl_rise;
  logic scl_fall;
  logic scl_held;
  logic sda;
  logic start_c;
  logic stop_c;

  assign sda      = now[1];
  assign scl_rise = now[0] & ~prev[0];
  assign scl_fall = ~now[0] & prev[0];
  assign scl_held = now[0] & prev[0];
  assign start_c  = scl_held & prev[1] & ~now[1];
  assign stop_c   = scl_held & ~prev[1] & now[1];

  // ==========================================================
  // register storage
  logic        wr_s;
  logic        rf_we;
  logic [5:0]  rf_waddr;
  logic [7:0]  rf_wdata;
  logic [5:0]  rd_idx;
  logic [7:0]  rd_byte;
  logic [7:0]  loc_byte;
  logic        loc_in_map;

  // reads past the top keep serving the highest register
  assign rd_idx = (q.ptr >= NUM_P) ? LAST_P : q.ptr;

  // serial write wins a same-cycle clash with the local port
  assign loc_in_map = reg_addr < NUM_P;
  assign rf_we      = wr_s | (reg_wr & loc_in_map);
  assign rf_waddr   = wr_s ? q.ptr : reg_addr;
  assign rf_wdata   = wr_s ? q.sh : reg_wdata;

  esh_regfile #(
    .NUM (NUM_REGS)
  ) u_regs (
    .clock   (clock),
    .rst_n   (rst_n),
    .we      (rf_we),
    .waddr   (rf_waddr),
    .wdata   (rf_wdata),
    .raddr_a (rd_idx),
    .rdata_a (rd_byte),
    .raddr_b (reg_addr),
    .rdata_b (loc_byte),
    .mode0   (first_mode_register),
    .freq    (subcarrier_freq)
  );

  // ==========================================================
  // byte decisions and local decode
  logic        asel_s;
  logic        byte_done;
  logic        addr_hit;
  logic        sub_valid;
  logic        wr_room;
  logic        rd_more;
  logic [3:0]  bits_inc;
  logic [5:0]  ptr_inc;
  logic        tx_first_low;
  logic        tx_next_low;

  logic        loc_ctrl_sel;
  logic        loc_stat_sel;

  assign asel_s       = now[2];
  // a byte ends on the fall after its eighth sampled rise
  assign byte_done    = scl_fall && q.bits == ESH_BITS_BYTE;
  // a disabled port acks no new address, so software can park it off the bus between transfers
  assign addr_hit     = (q.sh[7:1] == {SLAVE_ID, asel_s}) && q.ctrl[ESH_CTRL_EN];
  // whole byte compared, so set upper pointer bits make it invalid
  assign sub_valid    = q.sh < NUM_B;
  assign wr_room      = q.ptr < NUM_P;
  // read pointer saturates so the clamp keeps serving the top register
  assign rd_more      = q.ptr < LAST_P;
  assign bits_inc     = q.bits + 4'h1;
  assign ptr_inc      = q.ptr + 6'h01;
  // open drain: a zero bit goes out by driving the line
  assign tx_first_low = ~rd_byte[7];
  assign tx_next_low  = ~q.sh[6];

  assign loc_ctrl_sel = reg_addr == ESH_IDX_CTRL;
  assign loc_stat_sel = reg_addr == ESH_IDX_STAT;

  // ==========================================================
  // next state
  always_comb begin
    d       = q;
    wr_s    = 1'b0;
    d.rdata = ESH_ZERO_RST;

    // local port
    if (reg_rd) begin
      if (loc_ctrl_sel) begin
        d.rdata = q.ctrl;
      end else if (loc_stat_sel) begin
        d.rdata                = ESH_ZERO_RST;
        d.rdata[ESH_STAT_BUSY] = q.st != ESH_IDLE;
        d.rdata[ESH_STAT_READ] = q.rd_dir;
        d.rdata[ESH_STAT_DRV]  = q.oe;
      end else begin
        d.rdata = loc_byte;
      end
    end
    if (reg_wr && loc_ctrl_sel) begin
      d.ctrl = reg_wdata;
    end

    // serial side; stop then start in one high phase is seen in order
    if (stop_c) begin
      d.st = ESH_IDLE;
      d.oe = 1'b0;
    end else if (start_c) begin
      d.st   = ESH_ADDR;
      d.bits = '0;
      d.oe   = 1'b0;
    end else begin
      unique case (q.st)
        ESH_IDLE: begin
          d.oe = 1'b0;
        end
        ESH_ADDR, ESH_SUB, ESH_WR: begin
          if (scl_rise && q.bits != ESH_BITS_BYTE) begin
            d.sh   = {q.sh[6:0], sda};
            d.bits = bits_inc;
          end else if (byte_done) begin
            d.bits = '0;
            if (q.st == ESH_ADDR) begin
              d.rd_dir = q.sh[0];
              if (addr_hit) begin
                d.oe = 1'b1;
                d.st = ESH_ACK_ADDR;
              end else begin
                d.st = ESH_IDLE;
              end
            end else if (q.st == ESH_SUB) begin
              if (sub_valid) begin
                d.ptr = q.sh[5:0];
                d.oe  = 1'b1;
                d.st  = ESH_ACK_DATA;
              end else begin
                d.st = ESH_IDLE;
              end
            end else begin
              if (wr_room) begin
                wr_s  = 1'b1;
                d.ptr = ptr_inc;
                d.oe  = 1'b1;
                d.st  = ESH_ACK_DATA;
              end else begin
                d.st = ESH_IDLE;
              end
            end
          end
        end
        ESH_ACK_ADDR: begin
          if (scl_fall) begin
            d.bits = '0;
            if (q.rd_dir) begin
              d.sh = rd_byte;
              d.oe = tx_first_low;
              d.st = ESH_RD;
            end else begin
              d.oe = 1'b0;
              d.st = ESH_SUB;
            end
          end
        end
        ESH_ACK_DATA: begin
          if (scl_fall) begin
            d.oe = 1'b0;
            d.st = ESH_WR;
          end
        end
        ESH_RD: begin
          if (scl_rise) begin
            d.bits = bits_inc;
          end else if (scl_fall) begin
            if (q.bits == ESH_BITS_BYTE) begin
              d.oe = 1'b0;
              d.st = ESH_MACK;
            end else begin
              d.sh = {q.sh[6:0], 1'b0};
              d.oe = tx_next_low;
            end
          end
        end
        ESH_MACK: begin
          if (scl_rise) begin
            if (sda) begin
              d.st = ESH_IDLE;
            end else begin
              if (rd_more) begin
                d.ptr = ptr_inc;
              end
              d.st = ESH_MACK_OK;
            end
          end
        end
        ESH_MACK_OK: begin
          if (scl_fall) begin
            d.bits = '0;
            d.sh   = rd_byte;
            d.oe   = tx_first_low;
            d.st   = ESH_RD;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs; the pin is only ever pulled low
  assign serial_data_out           = 1'b0;
  assign serial_data_oe            = q.oe;
  assign reg_rdata                 = q.rdata;
  assign low_pixel_byte_inputs_sel = q.pix_low;

endmodule // esh_port

// ===== dv/esh_port_asserts.sv
/*
  checker for esh_port: reset image, data line drive and local reads.
  assumes bus pins change just after clock edges.
*/
`timescale 1ns/100ps
module esh_port_asserts
  import esh_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        serial_clock_pin,
  input wire logic        serial_data_in,
  input wire logic        serial_data_out,
  input wire logic        serial_data_oe,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [5:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic [7:0]  first_mode_register,
  input wire logic [31:0] subcarrier_freq,
  input wire logic        low_pixel_byte_inputs_sel
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // bus conditions
  sequence s_start;
    serial_clock_pin && $fell(serial_data_in);
  endsequence
  sequence s_stop;
    serial_clock_pin && $rose(serial_data_in);
  endsequence
  // ==========================================================
  // checks
  AST_START_QUIET: assert property (s_start |=> !serial_data_oe [*8])
    else $error("data line driven during address bits");
  AST_STOP_IDLE: assert property (s_stop |=> !serial_data_oe [*8])
    else $error("data line driven after stop");
  AST_ACK_HOLD: assert property ($rose(serial_data_oe) |-> serial_data_oe [*6])
    else $error("data line drive too short");
  AST_ACK_CLK_LOW: assert property ($rose(serial_data_oe) |-> !$past(serial_clock_pin, 2))
    else $error("data line driven while clock high");
  AST_PULL_LOW: assert property (serial_data_oe |-> serial_data_out == 1'b0)
    else $error("driven data level not low");
  AST_RST_MODE: assert property ($rose(rst_n) |-> first_mode_register == ESH_MODE0_RST)
    else $error("mode register reset value wrong");
  AST_RST_FREQ: assert property ($rose(rst_n) |-> subcarrier_freq == ESH_FREQ_RST)
    else $error("frequency reset value wrong");
  AST_RST_PIX: assert property ($rose(rst_n) |-> low_pixel_byte_inputs_sel && !serial_data_oe)
    else $error("pixel source or drive wrong after reset");
  AST_RDATA_GAP: assert property (!reg_rd |=> reg_rdata == ESH_ZERO_RST)
    else $error("read data outside read cycle");
  AST_MODE_WR: assert property (reg_wr && reg_addr == ESH_IDX_MODE0 && !serial_data_oe
    |=> first_mode_register == $past(reg_wdata))
    else $error("local mode write lost");
endmodule // esh_port_asserts

bind esh_port esh_port_asserts i_esh_port_asserts (
  .clock, .rst_n, .serial_clock_pin, .serial_data_in, .serial_data_out,
  .serial_data_oe, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
  .first_mode_register, .subcarrier_freq, .low_pixel_byte_inputs_sel
);

// ===== dv/esh_master.sv
/*
  behavioural two-wire bus master, 8 clocks per bit.
  assumes the data line has a pull-up and tasks are called after an edge.
*/
`timescale 1ns/100ps
module esh_master (
  input  wire logic clock,
  input  wire logic sda,
  output      logic scl,
  output      logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // ==========================================================
  // bit level
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic bitx(input logic b, output logic s);
    sda_low <= !b;
    tick(2);
    scl <= 1'b1;
    tick(4);
    s = sda;
    scl <= 1'b0;
    tick(2);
  endtask
  // data falls with clock high; release first so a repeat start works
  task automatic start();
    sda_low <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda_low <= 1'b1;
    tick(4);
    scl <= 1'b0;
    tick(2);
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda_low <= 1'b0;
    tick(4);
  endtask
  // ==========================================================
  // byte level, msb first
  task automatic wbyte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(v[i], s);
    bitx(1'b1, s);
    ack = !s;
  endtask
  task automatic rbyte(input logic mack, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, s);
      v[i] = s;
    end
    bitx(!mack, s);
  endtask
endmodule // esh_master

// ===== dv/esh_port_bench.sv
/*
  self-checking bench for esh_port: bus master model plus local port tasks.
  assumes the copy-protection register count and an open-drain data line.
*/
`timescale 1ns/100ps
module esh_port_bench
  import esh_pkg::*;
;
  localparam logic [5:0] ID = 6'h15;  // arbitrary value
  localparam logic [7:0] TOP = 8'(ESH_REGS_COPY - 1);
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        asel = 1'b0;
  logic [5:0]  reg_addr = 6'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata, mode0;
  logic [31:0] freq;
  logic        pix, sdo, oe, scl, m_low, sda;
  int          num_errors = 0;
  int          comparisons = 0;

  always #20 clock = ~clock;
  // pull-up unless someone pulls low
  assign sda = (oe ? sdo : 1'b1) & !m_low;

  esh_port i_esh_port (
    .clock                     (clock),
    .rst_n                     (rst_n),
    .serial_clock_pin          (scl),
    .serial_data_in            (sda),
    .serial_data_out           (sdo),
    .serial_data_oe            (oe),
    .address_select_pin        (asel),
    .reg_addr                  (reg_addr),
    .reg_wdata                 (reg_wdata),
    .reg_wr                    (reg_wr),
    .reg_rd                    (reg_rd),
    .reg_rdata                 (reg_rdata),
    .first_mode_register       (mode0),
    .subcarrier_freq           (freq),
    .low_pixel_byte_inputs_sel (pix)
  );
  esh_master i_esh_master (.clock(clock), .sda(sda), .scl(scl), .sda_low(m_low));

  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic lrd(input logic [5:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    // take the byte mid cycle, while it stands
    @(negedge clock);
    d = reg_rdata;
    @(posedge clock);
  endtask
  task automatic lwr(input logic [5:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic send(input logic [7:0] v, input logic ea);
    logic a;
    i_esh_master.wbyte(v, a);
    chk(32'(a), 32'(ea));
  endtask
  task automatic recv(input logic mack, input logic [7:0] e);
    logic [7:0] v;
    i_esh_master.rbyte(mack, v);
    chk(32'(v), 32'(e));
  endtask
  function automatic logic [7:0] rstv(input int i);
    if (i == 0) return ESH_MODE0_RST;
    if (i >= 2 && i <= 5) return ESH_FREQ_RST[8*(i-2) +: 8];
    return ESH_ZERO_RST;
  endfunction
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ==========================================================
  // tests
  initial begin
    logic [7:0] d;
    logic       b;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    for (int i = 0; i < ESH_REGS_COPY; i++) begin
      lrd(6'(i), d);
      chk(32'(d), 32'(rstv(i)));
    end
    chk(32'(pix), 32'h1);
    $display("test reset done");
    i_esh_master.start();
    send({ID, 2'b00}, 1'b1);
    send({2'b00, ESH_IDX_FREQ0}, 1'b1);
    for (int i = 1; i <= 4; i++) send(8'(17 * i), 1'b1);
    i_esh_master.stop();
    chk(freq, 32'h44332211);
    i_esh_master.start();
    send({ID, 2'b00}, 1'b1);
    send({2'b00, ESH_IDX_FREQ0}, 1'b1);
    i_esh_master.start();
    send({ID, 2'b01}, 1'b1);
    for (int i = 1; i <= 4; i++) recv(i < 4, 8'(17 * i));
    i_esh_master.stop();
    $display("test auto increment done");
    asel <= 1'b1;
    repeat (4) @(posedge clock);
    i_esh_master.start();
    send({ID, 2'b00}, 1'b0);
    i_esh_master.stop();
    i_esh_master.start();
    send({ID, 2'b10}, 1'b1);
    send(8'(ESH_REGS_COPY), 1'b0);
    i_esh_master.stop();
    i_esh_master.start();
    send({ID, 2'b10}, 1'b1);
    send(8'h40, 1'b0);
    i_esh_master.stop();
    i_esh_master.start();
    send({ID, 2'b10}, 1'b1);
    send(TOP, 1'b1);
    send(8'haa, 1'b1);
    send(8'hbb, 1'b0);
    i_esh_master.stop();
    lrd(TOP[5:0], d);
    chk(32'(d), 32'haa);
    i_esh_master.start();
    send({ID, 2'b11}, 1'b1);
    for (int i = 0; i < 3; i++) recv(i < 2, 8'haa);
    i_esh_master.stop();
    $display("test boundaries done");
    i_esh_master.start();
    for (int i = 0; i < 3; i++) i_esh_master.bitx(1'b1, b);
    i_esh_master.stop();
    lrd(ESH_IDX_STAT, d);
    chk(32'(d[ESH_STAT_BUSY]), 32'h0);
    chk(32'(d[ESH_STAT_READ]), 32'h1);
    chk(32'(d[ESH_STAT_DRV]), 32'h0);
    i_esh_master.start();
    send({ID, 2'b10}, 1'b1);
    send(8'h00, 1'b1);
    for (int i = 0; i < 4; i++) i_esh_master.bitx(1'b0, b);
    i_esh_master.start();
    send({ID, 2'b11}, 1'b1);
    recv(1'b0, ESH_MODE0_RST);
    i_esh_master.stop();
    lwr(ESH_IDX_MODE0, 8'h5a);
    lrd(ESH_IDX_MODE0, d);
    chk(32'(d), 32'h5a);
    chk(32'(mode0), 32'h5a);
    lrd(ESH_IDX_CTRL, d);
    chk(32'(d), 32'(ESH_CTRL_RST));
    lwr(ESH_IDX_CTRL, 8'h00);
    i_esh_master.start();
    send({ID, 2'b10}, 1'b0);
    i_esh_master.stop();
    lwr(ESH_IDX_CTRL, ESH_CTRL_RST);
    $display("test abort and local done");
    rst_n <= 1'b0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    chk(32'(mode0), 32'(ESH_MODE0_RST));
    chk(freq, ESH_FREQ_RST);
    lrd(TOP[5:0], d);
    chk(32'(d), 32'(ESH_ZERO_RST));
    chk(32'(pix), 32'h1);
    $display("test second reset done");
    summarize();
  end

  // whole run is about 2700 cycles
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    summarize();
  end
endmodule // esh_port_bench
